// ### hw/config_data_port_pins.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module config_data_port_pins
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic parallel_cfg_mode_i,
  input wire logic persist_i,
  input wire logic start_i,
  input wire logic [7:0] cfg_byte_bus_i,
  input wire logic sel_n_i,
  input wire logic xfer_direction_i,
  input wire logic [7:0] user_o_i,
  input wire logic [7:0] user_oe_i,
  input wire logic [7:0] total_bytes_i,
  output logic [7:0] cfg_byte_bus_o,
  output logic [7:0] cfg_byte_bus_oe_o,
  output logic busy_dout_o,
  output logic busy_dout_oe_o,
  output logic init_status_o,
  output logic init_status_oe_o,
  output logic cfg_done_o,
  output logic port_kept_o,
  output logic [7:0] user_in_o,
  output logic user_sel_n_o,
  output logic user_dir_o
);

////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    cfg_port_pkg::par_pins_t s1;
    cfg_port_pkg::par_pins_t s2;
    cfg_port_pkg::par_pins_t s3;
    cfg_port_pkg::par_pins_t pins;
    cfg_port_pkg::phase_t phase;
    logic [3:0] busy_cnt;
    logic [2:0] bit_cnt;
    logic [3:0] ser_cnt;
    logic [7:0] shift;
    logic [31:0] word;
    logic [1:0] byte_idx;
    logic [1:0] wptr;
    logic synced;
    logic [7:0] count;
    logic [7:0] last_byte;
    logic wr;
    logic [7:0] bus_o;
    logic [7:0] bus_oe;
    logic busy;
    logic busy_oe;
    logic init_oe;
    logic done;
    logic kept;
    logic [7:0] uin;
    logic usel;
    logic udir;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [31:0] rd_word;
  logic sel_ok;
  logic dir_ok;

  cfg_word_store store_u
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .wr_i(state_reg.wr),
    .waddr_i(state_reg.wptr),
    .wdata_i(state_reg.word),
    .raddr_i(state_reg.wptr),
    .rdata_o(rd_word)
  );

////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    state_next.wr = 1'b0;
    state_next.s1 = '{data: cfg_byte_bus_i, sel_n: sel_n_i,
                      dir: xfer_direction_i};
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    // a pin change counts only once two late stages agree
    if (state_reg.s2 == state_reg.s3)
    begin
      state_next.pins = state_reg.s3;
    end
    sel_ok = !state_reg.pins.sel_n;
    dir_ok = !state_reg.pins.dir;
    if (state_reg.busy_cnt != 4'h0)
    begin
      state_next.busy_cnt = state_reg.busy_cnt - 4'h1;
    end
    unique case (state_reg.phase)
      cfg_port_pkg::ST_IDLE:
      begin
        if (start_i)
        begin
          state_next.phase = cfg_port_pkg::ST_LOAD;
          state_next.count = 8'h00;
          state_next.synced = 1'b0;
          state_next.byte_idx = 2'h0;
          state_next.bit_cnt = cfg_port_pkg::BIT_RST;
          state_next.ser_cnt = cfg_port_pkg::SER_FIRST;
        end
      end
      cfg_port_pkg::ST_LOAD:
      begin
        if (parallel_cfg_mode_i)
        begin
          // busy, then a guard long enough for the host's next byte to
          // pass the pin synchroniser, so a held byte is never taken twice
          if (sel_ok && dir_ok && state_reg.busy_cnt == 4'h0)
          begin
            state_next.last_byte = state_reg.pins.data;
            state_next.busy_cnt = 4'(cfg_port_pkg::BUSY_CYC
              + cfg_port_pkg::GUARD_CYC);
            state_next.count = state_reg.count + 8'h01;
          end
          // a read during configuration is meaningless: flag it
          if (sel_ok && !dir_ok)
          begin
            state_next.phase = cfg_port_pkg::ST_FAIL;
          end
        end
        else
        begin
          // no bit clock: the host starts its first bit on the edge that
          // begins the load and holds each bit for a fixed period; it is
          // taken mid-bit so the agree stage has settled
          if (state_reg.ser_cnt != 4'h0)
          begin
            state_next.ser_cnt = state_reg.ser_cnt - 4'h1;
          end
          else
          begin
            // only bit zero is used
            state_next.ser_cnt = 4'(cfg_port_pkg::SER_CYC - 4'h1);
            state_next.shift = {state_reg.shift[6:0],
                                state_reg.pins.data[0]};
            state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
            if (state_reg.bit_cnt == 3'h7)
            begin
              state_next.last_byte = {state_reg.shift[6:0],
                                      state_reg.pins.data[0]};
              state_next.count = state_reg.count + 8'h01;
            end
          end
        end
        if (state_next.count != state_reg.count)
        begin
          state_next.word = {state_reg.word[23:0], state_next.last_byte};
          state_next.byte_idx = state_reg.byte_idx + 2'h1;
          if (state_reg.byte_idx == 2'h3)
          begin
            if (!state_reg.synced)
            begin
              state_next.synced =
                {state_reg.word[23:0], state_next.last_byte}
                == cfg_port_pkg::SYNC_WORD;
              state_next.byte_idx = state_next.synced ? 2'h0 : 2'h3;
            end
            else
            begin
              state_next.wr = 1'b1;
              state_next.wptr = state_reg.wptr + 2'h1;
            end
          end
          if (state_next.count == total_bytes_i)
          begin
            state_next.phase = state_next.synced ? cfg_port_pkg::ST_DONE
                                                 : cfg_port_pkg::ST_FAIL;
          end
        end
      end
      cfg_port_pkg::ST_DONE:
      begin
        state_next.phase = cfg_port_pkg::ST_DONE;
      end
      cfg_port_pkg::ST_FAIL:
      begin
        if (start_i)
        begin
          state_next.phase = cfg_port_pkg::ST_IDLE;
        end
      end
    endcase
    state_next.done = state_next.phase == cfg_port_pkg::ST_DONE;
    state_next.kept = state_next.done && persist_i;
    // open drain: enable means pull low
    state_next.init_oe = state_next.phase == cfg_port_pkg::ST_FAIL;
    if (state_next.done && !persist_i)
    begin
      // hand pins to user logic
      state_next.bus_o = user_o_i;
      state_next.bus_oe = user_oe_i;
      state_next.busy = 1'b0;
      state_next.busy_oe = 1'b0;
      state_next.uin = state_reg.pins.data;
      state_next.usel = state_reg.pins.sel_n;
      state_next.udir = state_reg.pins.dir;
    end
    else
    begin
      state_next.uin = 8'h00;
      state_next.usel = 1'b1;
      state_next.udir = 1'b0;
      // persisted port may serve reads of the low byte of the last stored word
      state_next.bus_o = rd_word[7:0];
      state_next.bus_oe = {8{state_next.kept && sel_ok && !dir_ok}};
      // a failed load is still configuration, so busy stays driven there
      state_next.busy_oe = state_next.phase == cfg_port_pkg::ST_LOAD
                           || state_next.phase == cfg_port_pkg::ST_FAIL
                           || state_next.kept;
      if (parallel_cfg_mode_i)
      begin
        // the guard tail of the count is not shown as busy
        state_next.busy = state_next.busy_cnt > cfg_port_pkg::GUARD_CYC;
      end
      else
      begin
        state_next.busy = state_reg.pins.data[0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= '0;
      state_reg.s1.sel_n <= 1'b1;
      state_reg.s2.sel_n <= 1'b1;
      state_reg.s3.sel_n <= 1'b1;
      state_reg.pins.sel_n <= 1'b1;
      state_reg.usel <= 1'b1;
      state_reg.busy_cnt <= cfg_port_pkg::BUSY_RST;
      state_reg.word <= cfg_port_pkg::CHECK_INIT;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign cfg_byte_bus_o = state_reg.bus_o;
  assign cfg_byte_bus_oe_o = state_reg.bus_oe;
  assign busy_dout_o = state_reg.busy;
  assign busy_dout_oe_o = state_reg.busy_oe;
  assign init_status_o = 1'b0;
  assign init_status_oe_o = state_reg.init_oe;
  assign cfg_done_o = state_reg.done;
  assign port_kept_o = state_reg.kept;
  assign user_in_o = state_reg.uin;
  assign user_sel_n_o = state_reg.usel;
  assign user_dir_o = state_reg.udir;

endmodule // config_data_port_pins

// ### hw/cfg_port_pkg.sv
package cfg_port_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned DEPTH = 4;
  localparam int unsigned PTR_W = 2;
  localparam int unsigned WORD_W = 32;
  // busy is held for this long after every byte accepted in parallel mode, except the byte that ends a load in done without persist
  localparam int unsigned BUSY_NS = 32;
  localparam int unsigned CLK_NS = 8;
  localparam logic [3:0] BUSY_CYC = 4'((BUSY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] BUSY_RST = 4'h0;
  // quiet time after busy falls: covers the pin path plus the host's reaction
  localparam logic [3:0] GUARD_CYC = 4'h5;
  // serial: clocks per bit, and one less than the clocks from load start to the first mid-bit
  localparam logic [3:0] SER_CYC = 4'h4;
  localparam logic [3:0] SER_FIRST = 4'h6;
  localparam logic [2:0] BIT_RST = 3'h0;
  // four-byte word of a stream that must be seen before data is stored
  localparam logic [31:0] SYNC_WORD = 32'haa99_5566;
  localparam logic [31:0] CHECK_INIT = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_DONE = 2'b10,
    ST_FAIL = 2'b11
  } phase_t;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic sel_n;
    logic dir;
  } par_pins_t;

  typedef struct packed {
    logic [BYTE_W-1:0] o;
    logic [BYTE_W-1:0] oe;
  } user_drive_t;

endpackage

// ### hw/cfg_word_store.sv
`timescale 1ns/1ps
// small store of assembled configuration words, registered read
module cfg_word_store
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [cfg_port_pkg::PTR_W-1:0] waddr_i,
  input wire logic [cfg_port_pkg::WORD_W-1:0] wdata_i,
  input wire logic [cfg_port_pkg::PTR_W-1:0] raddr_i,
  output logic [cfg_port_pkg::WORD_W-1:0] rdata_o
);

  logic [cfg_port_pkg::WORD_W-1:0] mem [cfg_port_pkg::DEPTH];

  always_ff @(posedge clock_i)
  begin
    if (wr_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= cfg_port_pkg::CHECK_INIT;
    end
    else
    begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule // cfg_word_store

// ### dv/port_pins_checker.sv
`timescale 1ns/1ps
module port_pins_checker
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic parallel_cfg_mode_i,
  input wire logic persist_i,
  input wire logic [7:0] cfg_byte_bus_i,
  input wire logic [7:0] cfg_byte_bus_oe_o,
  input wire logic busy_dout_o,
  input wire logic busy_dout_oe_o,
  input wire logic init_status_oe_o,
  input wire logic cfg_done_o,
  input wire logic port_kept_o,
  input wire logic [7:0] user_in_o,
  input wire logic user_sel_n_o,
  input wire logic user_dir_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  busy_width_a: assert property (
    $rose(busy_dout_o) && parallel_cfg_mode_i
    |-> busy_dout_o [*4] ##1 !busy_dout_o) else $error("busy width");
  busy_drive_a: assert property (
    parallel_cfg_mode_i && !cfg_done_o && busy_dout_o |-> busy_dout_oe_o)
    else $error("busy undriven");
  serial_fwd_a: assert property (
    busy_dout_oe_o && !parallel_cfg_mode_i && !cfg_done_o
    && $past(!parallel_cfg_mode_i, 5) && $past(nrst_i, 6)
    |-> busy_dout_o == $past(cfg_byte_bus_i[0], 5)) else $error("forward");
  bus_input_a: assert property (
    !cfg_done_o |-> cfg_byte_bus_oe_o == 8'h00) else $error("bus driven");
  user_idle_a: assert property (
    !cfg_done_o |-> user_sel_n_o && !user_dir_o && user_in_o == 8'h00)
    else $error("user view early");
  kept_role_a: assert property (
    port_kept_o |-> cfg_done_o && persist_i) else $error("kept wrong");
  error_flag_a: assert property (
    $rose(init_status_oe_o) |-> !cfg_done_o) else $error("error after done");
  done_hold_a: assert property (
    cfg_done_o |=> cfg_done_o && !init_status_oe_o) else $error("done lost");
endmodule // port_pins_checker
bind config_data_port_pins port_pins_checker u_chk (.clock_i, .nrst_i,
  .parallel_cfg_mode_i, .persist_i, .cfg_byte_bus_i, .cfg_byte_bus_oe_o,
  .busy_dout_o, .busy_dout_oe_o, .init_status_oe_o, .cfg_done_o,
  .port_kept_o, .user_in_o, .user_sel_n_o, .user_dir_o);

// ### dv/cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model
(
  input wire logic clock_i,
  input wire logic mode_i,
  input wire logic busy_i,
  output cfg_port_pkg::par_pins_t pins_o
);
  logic [7:0] q[$];
  initial pins_o = '{data: 8'h00, sel_n: 1'b1, dir: 1'b1};
  // bad_at names the byte turned into a read, to provoke the error path
  task automatic send(input int bad_at);
    logic [7:0] b;
    int n;
    int w;
    for (n = 0; q.size() > 0; n++)
    begin
      b = q.pop_front();
      if (mode_i)
      begin
        pins_o <= '{data: b, sel_n: 1'b0, dir: n == bad_at};
        if (n == bad_at)
        begin
          repeat (8) @(posedge clock_i);
          q.delete();
        end
        for (w = 0; w < 20 && !busy_i; w++) @(posedge clock_i);
        for (w = 0; w < 20 && busy_i; w++) @(posedge clock_i);
      end
      else
        for (w = 7; w >= 0; w--)
        begin
          // first bit leaves on the edge that starts the load
          pins_o.data <= {~pins_o.data[7:1], b[w]};
          repeat (cfg_port_pkg::SER_CYC) @(posedge clock_i);
        end
    end
    // released lines must not keep showing the last byte
    pins_o <= '{data: ~pins_o.data, sel_n: 1'b1, dir: 1'b1};
  endtask
endmodule // cfg_host_model

// ### dv/test_config_data_port_pins.sv
`timescale 1ns/1ps
module test_config_data_port_pins;
  logic clock_i, nrst_i, mode, persist, start, busy, busy_oe;
  logic init_o, init_oe, done, kept, usel_n, udir, ok;
  logic [7:0] user_o, user_oe, total, bus_o, bus_oe, user_in, b;
  logic [31:0] word;
  cfg_port_pkg::par_pins_t pins;
  int errors, total_checks, seed, t, i, n, bad;
  config_data_port_pins u_dut (.clock_i, .nrst_i,
    .parallel_cfg_mode_i(mode), .persist_i(persist), .start_i(start),
    .cfg_byte_bus_i(pins.data), .sel_n_i(pins.sel_n),
    .xfer_direction_i(pins.dir), .user_o_i(user_o), .user_oe_i(user_oe),
    .total_bytes_i(total), .cfg_byte_bus_o(bus_o), .cfg_byte_bus_oe_o(bus_oe),
    .busy_dout_o(busy), .busy_dout_oe_o(busy_oe), .init_status_o(init_o),
    .init_status_oe_o(init_oe), .cfg_done_o(done), .port_kept_o(kept),
    .user_in_o(user_in), .user_sel_n_o(usel_n), .user_dir_o(udir));
  cfg_host_model u_host (.clock_i, .mode_i(mode), .busy_i(busy),
    .pins_o(pins));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock_i = 0;
    forever #4 clock_i = ~clock_i;
  end
  initial
  begin
    #200000;
    errors++;
    final_report();
  end
  // runs: plain, persisted, bad sync word, read mid-load, serial
  initial
  begin
    {seed, errors, total_checks} = {32'd49, 32'd0, 32'd0};
    {nrst_i, mode, persist, start, user_o, user_oe, total} = '0;
    for (t = 0; t < 5; t++)
    begin
      nrst_i <= 0;
      mode <= t != 4;
      persist <= t == 1;
      n = 1 + ($unsigned($random(seed)) % 4);
      bad = t == 3 ? 2 : -1;
      word = cfg_port_pkg::SYNC_WORD ^ {31'h0, t == 2};
      ok = word === cfg_port_pkg::SYNC_WORD && bad < 0;
      total <= 8'(4 + n);
      for (i = 0; i < 4; i++) u_host.q.push_back(word[31 - 8 * i -: 8]);
      for (i = 0; i < n; i++)
      begin
        b = 8'($random(seed));
        u_host.q.push_back(b);
      end
      repeat (3) @(posedge clock_i);
      nrst_i <= 1;
      start <= 1;
      @(posedge clock_i);
      start <= 0;
      u_host.send(bad);
      for (i = 0; i < 60 && !(done | init_oe); i++) @(posedge clock_i);
      repeat (8) @(posedge clock_i);
      check(done, ok);
      check(init_oe, !ok);
      check(kept, ok && persist);
      check({init_o, busy_oe}, {1'b0, !ok || persist});
      if (ok && t == 0)
      begin
        check({user_in, usel_n, udir}, {~b, 2'b11});
        user_o <= 8'($random(seed));
        user_oe <= 8'($random(seed));
        repeat (4) @(posedge clock_i);
        check({bus_o, bus_oe}, {user_o, user_oe});
      end
      if (!ok)
      begin
        start <= 1;
        @(posedge clock_i);
        start <= 0;
        repeat (3) @(posedge clock_i);
        check(init_oe, 1'b0);
      end
    end
    final_report();
  end
endmodule // test_config_data_port_pins
